// File: core/ipw_pkg.sv
package ipw_pkg;

    // Register port widths.
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;

    // Register offsets on the microprocessor port.
    localparam logic [6:0] INT_CFG_ADDR = 7'h7D;
    localparam logic [6:0] KEY_ADDR = 7'h7E;

    // Values after reset.
    localparam logic [7:0] INT_CFG_RST = 8'h02;
    localparam logic [7:0] KEY_RST = 8'h85;

    // Key values that open the register file.
    localparam logic [7:0] KEY_FULL_OPEN = 8'h85;
    localparam logic [7:0] KEY_SINGLE_OPEN = 8'h86;
    // Value loaded after the one permitted write; any protected value would do.
    localparam logic [7:0] KEY_RELOCK = 8'h00;

    // Field positions of the interrupt pin configuration register.
    localparam int POL_BIT = 0;
    localparam int TRI_BIT = 1;
    localparam int GPO_BIT = 2;
    localparam int CFG_W = 3;

    // Reset state of the registered pin outputs (idle, released, inactive high).
    localparam logic PIN_LVL_RST = 1'b1;
    localparam logic PIN_OE_N_RST = 1'b1;

    // Protection modes.
    typedef enum logic [1:0] {
        IPW_PROTECTED,
        IPW_FULL_OPEN,
        IPW_SINGLE_OPEN
    } ipw_mode_t;

    // Decodes the key register into a protection mode.
    function automatic ipw_mode_t key_mode(input logic [7:0] key);
        if (key == KEY_FULL_OPEN) begin
            return IPW_FULL_OPEN;
        end else if (key == KEY_SINGLE_OPEN) begin
            return IPW_SINGLE_OPEN;
        end else begin
            return IPW_PROTECTED;
        end
    endfunction

endpackage

// File: core/ipw_key_guard.sv
`timescale 1ns/100ps
module ipw_key_guard (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic reset_in,
    // Register write request.
    input wire logic wr_in,
    input wire logic [6:0] addr_in,
    input wire logic [7:0] data_in,
    // Key state and write permission.
    output logic [7:0] key_out,
    output logic grant_out
);

    typedef struct packed {
        logic [7:0] key;
    } ipw_guard_t;

    ipw_guard_t state_r;
    ipw_guard_t state_nxt;
    ipw_pkg::ipw_mode_t mode;

    // Other registers are writable only while the key opens them; the key itself always is.
    always_comb begin
        mode = ipw_pkg::key_mode(state_r.key);
        grant_out = wr_in && (addr_in != ipw_pkg::KEY_ADDR) && (mode != ipw_pkg::IPW_PROTECTED); // R8 R9 R10
        state_nxt = state_r;
        if (wr_in && addr_in == ipw_pkg::KEY_ADDR) begin
            state_nxt.key = data_in; // R12
        end else if (grant_out && mode == ipw_pkg::IPW_SINGLE_OPEN) begin
            state_nxt.key = ipw_pkg::KEY_RELOCK; // R10
        end
    end

    // Key register; reset leaves the device fully open.
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            state_r.key <= ipw_pkg::KEY_RST; // R11
        end else begin
            state_r <= state_nxt;
        end
    end

    assign key_out = state_r.key;

endmodule // ipw_key_guard

// File: core/ipw_pin_drive.sv
`timescale 1ns/100ps
module ipw_pin_drive (
    // Configuration fields.
    input wire logic gpo_sel_in,
    input wire logic tri_en_in,
    input wire logic pol_in,
    // Interrupt request from the device.
    input wire logic irq_in,
    // Pin level and enable, enable low while driving.
    output logic lvl_out,
    output logic oe_n_out
);

    // Works out the level and drive of the shared interrupt pin.
    always_comb begin
        if (gpo_sel_in) begin
            lvl_out = pol_in; // R1 R2
            oe_n_out = 1'b0;
        end else if (irq_in) begin
            lvl_out = pol_in; // R5
            oe_n_out = 1'b0;
        end else begin
            lvl_out = ~pol_in; // R3
            oe_n_out = tri_en_in; // R3 R4
        end
    end

endmodule // ipw_pin_drive

// File: core/ipw_top.sv
`timescale 1ns/100ps
// Functional notes
// R1 - Select bit two picks interrupt or output.
// R2 - Output mode drives pin to polarity bit.
// R3 - Tristate off drives idle pin inactive.
// R4 - Tristate on releases pin while idle.
// R5 - Polarity bit selects active pin level.
// R6 - Pin configuration resets to 0x02.
// R7 - Host writes key before other registers.
// R8 - Protected keys block other register writes.
// R9 - Key 0x85 opens all writes.
// R10 - Key 0x86 allows one write, relocks.
// R11 - Key register resets to 0x85.
// R12 - Key always writable, never consumes permit.
module ipw_top (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic reset_in,
    // Microprocessor register port.
    input wire logic [6:0] addr_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [7:0] wr_data_in,
    output logic [7:0] rd_data_out,
    output logic rd_valid_out,
    // Permitted writes passed on to the rest of the register file.
    output logic ext_wr_out,
    output logic [6:0] ext_addr_out,
    output logic [7:0] ext_data_out,
    // Interrupt request from the device's event logic.
    input wire logic irq_in,
    // Interrupt pin, enable low while driving.
    output logic irq_pin_out,
    output logic irq_pin_oe_n_out
);

    typedef struct packed {
        logic [2:0] cfg;
        logic pin_lvl;
        logic pin_oe_n;
        logic [7:0] rd_data;
        logic rd_valid;
        logic ext_wr;
        logic [6:0] ext_addr;
        logic [7:0] ext_data;
    } ipw_state_t;

    ipw_state_t state_r;
    ipw_state_t state_nxt;
    logic [7:0] key;
    logic grant;
    logic drv_lvl;
    logic drv_oe_n;

    // Key register and write permission.
    ipw_key_guard u_guard (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .wr_in(wr_in),
        .addr_in(addr_in),
        .data_in(wr_data_in),
        .key_out(key),
        .grant_out(grant)
    );

    // Pin level and drive from the configuration.
    ipw_pin_drive u_pin (
        .gpo_sel_in(state_r.cfg[ipw_pkg::GPO_BIT]),
        .tri_en_in(state_r.cfg[ipw_pkg::TRI_BIT]),
        .pol_in(state_r.cfg[ipw_pkg::POL_BIT]),
        .irq_in(irq_in),
        .lvl_out(drv_lvl),
        .oe_n_out(drv_oe_n)
    );

    // Next state: configuration writes, read data and forwarded writes.
    always_comb begin
        state_nxt = state_r;
        state_nxt.pin_lvl = drv_lvl; // R1 R2 R5
        state_nxt.pin_oe_n = drv_oe_n; // R3 R4
        state_nxt.ext_wr = 1'b0;
        state_nxt.rd_valid = rd_in;
        if (grant && addr_in == ipw_pkg::INT_CFG_ADDR) begin
            state_nxt.cfg = wr_data_in[ipw_pkg::CFG_W-1:0]; // R8 R9 R10
        end
        if (grant && addr_in != ipw_pkg::INT_CFG_ADDR) begin
            state_nxt.ext_wr = 1'b1; // R8 R9 R10
            state_nxt.ext_addr = addr_in;
            state_nxt.ext_data = wr_data_in;
        end
        if (rd_in) begin
            case (addr_in)
                ipw_pkg::INT_CFG_ADDR: begin
                    state_nxt.rd_data = {5'h0, state_r.cfg};
                end
                ipw_pkg::KEY_ADDR: begin
                    state_nxt.rd_data = key;
                end
                default: begin
                    state_nxt.rd_data = 8'h00;
                end
            endcase
        end
    end

    // State register.
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            state_r.cfg <= ipw_pkg::INT_CFG_RST[ipw_pkg::CFG_W-1:0]; // R6
            state_r.pin_lvl <= ipw_pkg::PIN_LVL_RST;
            state_r.pin_oe_n <= ipw_pkg::PIN_OE_N_RST;
            state_r.rd_data <= 8'h00;
            state_r.rd_valid <= 1'b0;
            state_r.ext_wr <= 1'b0;
            state_r.ext_addr <= 7'h00;
            state_r.ext_data <= 8'h00;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Outputs come straight from the state register.
    assign rd_data_out = state_r.rd_data;
    assign rd_valid_out = state_r.rd_valid;
    assign ext_wr_out = state_r.ext_wr;
    assign ext_addr_out = state_r.ext_addr;
    assign ext_data_out = state_r.ext_data;
    assign irq_pin_out = state_r.pin_lvl;
    assign irq_pin_oe_n_out = state_r.pin_oe_n;

    // Checks on the behaviour of the pin and of the write protection.
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (reset_in);

    // Output mode drives the pin to the polarity bit one cycle later.
    gpo_pin_level_a: assert property ( // R1 R2
        state_r.cfg[ipw_pkg::GPO_BIT]
        |=> (irq_pin_oe_n_out == 1'b0) && (irq_pin_out == $past(state_r.cfg[ipw_pkg::POL_BIT]))
    ) else $error("general output mode pin level wrong");

    // Output mode ignores the interrupt request.
    gpo_ignores_irq_a: assert property ( // R1
        (state_r.cfg[ipw_pkg::GPO_BIT] && $changed(irq_in) && $stable(state_r.cfg))
        |=> $stable(irq_pin_out) && $stable(irq_pin_oe_n_out)
    ) else $error("pin follows interrupt in general output mode");

    // A driven idle pin sits at the inactive level.
    idle_driven_a: assert property ( // R3
        (!state_r.cfg[ipw_pkg::GPO_BIT] && !state_r.cfg[ipw_pkg::TRI_BIT] && !irq_in)
        |=> !irq_pin_oe_n_out && (irq_pin_out != $past(state_r.cfg[ipw_pkg::POL_BIT]))
    ) else $error("idle pin not driven inactive");

    // An idle pin in shared mode is released.
    idle_released_a: assert property ( // R4
        (!state_r.cfg[ipw_pkg::GPO_BIT] && state_r.cfg[ipw_pkg::TRI_BIT] && !irq_in)
        |=> irq_pin_oe_n_out
    ) else $error("idle pin not released in shared mode");

    // An active interrupt drives the pin to the polarity level.
    irq_active_a: assert property ( // R4 R5
        (!state_r.cfg[ipw_pkg::GPO_BIT] && irq_in)
        |=> !irq_pin_oe_n_out && (irq_pin_out == $past(state_r.cfg[ipw_pkg::POL_BIT]))
    ) else $error("active interrupt level wrong");

    // Configuration leaves reset at 0x02.
    cfg_reset_a: assert property ( // R6
        $fell(reset_in) |-> (state_r.cfg == ipw_pkg::INT_CFG_RST[ipw_pkg::CFG_W-1:0])
    ) else $error("configuration reset value wrong");

    // Writes to other registers are dropped while protected.
    protect_blocks_a: assert property ( // R8
        (wr_in && addr_in != ipw_pkg::KEY_ADDR && ipw_pkg::key_mode(key) == ipw_pkg::IPW_PROTECTED)
        |=> !ext_wr_out && $stable(state_r.cfg)
    ) else $error("write passed while protected");

    // Fully open key forwards every write outside the key and configuration registers and stays open.
    full_open_a: assert property ( // R9
        (wr_in && addr_in != ipw_pkg::KEY_ADDR && addr_in != ipw_pkg::INT_CFG_ADDR
            && ipw_pkg::key_mode(key) == ipw_pkg::IPW_FULL_OPEN)
        |=> ext_wr_out && (ext_addr_out == $past(addr_in)) && (key == ipw_pkg::KEY_FULL_OPEN)
    ) else $error("open write not forwarded");

    // Single open key accepts one write to another register and then relocks.
    single_relock_a: assert property ( // R10
        (wr_in && addr_in != ipw_pkg::KEY_ADDR && ipw_pkg::key_mode(key) == ipw_pkg::IPW_SINGLE_OPEN)
        |=> (key == ipw_pkg::KEY_RELOCK) && (ext_wr_out == ($past(addr_in) != ipw_pkg::INT_CFG_ADDR))
    ) else $error("single open mode did not relock");

    // Key leaves reset fully open.
    key_reset_a: assert property ( // R11
        $fell(reset_in) |-> (key == ipw_pkg::KEY_RST)
    ) else $error("key reset value wrong");

    // The key is written in every mode and the write is never forwarded.
    key_write_a: assert property ( // R12
        (wr_in && addr_in == ipw_pkg::KEY_ADDR) |=> (key == $past(wr_data_in)) && !ext_wr_out
    ) else $error("key write lost or forwarded");

    // Read of the configuration shows the stored fields with upper bits zero.
    cfg_read_a: assert property (
        (rd_in && addr_in == ipw_pkg::INT_CFG_ADDR)
        |=> rd_valid_out && (rd_data_out == {5'h0, $past(state_r.cfg)})
    ) else $error("configuration read wrong");

endmodule // ipw_top

// File: tb/ipw_host_model.sv
`timescale 1ns/100ps
// Host processor model that performs single register reads and writes.
module ipw_host_model (
    // Clock.
    input wire logic clk_in,
    // Register port towards the device.
    output logic [6:0] addr_out,
    output logic wr_out,
    output logic rd_out,
    output logic [7:0] data_out,
    input wire logic [7:0] rd_data_in,
    input wire logic rd_valid_in,
    input wire logic ext_wr_in
);
    logic [7:0] rd_val;
    logic rd_ok;
    logic ext_seen;

    // The port idles with no request at time zero.
    initial begin
        addr_out = 7'h00;
        wr_out = 1'b0;
        rd_out = 1'b0;
        data_out = 8'h00;
    end

    // One write, then the lines show the inverse so stale values are never trusted.
    task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_out <= a;
        data_out <= d;
        wr_out <= 1'b1;
        @(posedge clk_in);
        wr_out <= 1'b0;
        addr_out <= ~a;
        data_out <= ~d;
        @(negedge clk_in);
        ext_seen = ext_wr_in;
    endtask

    // One read; the answer is taken in the cycle that it stands.
    task automatic rd_reg(input logic [6:0] a);
        @(posedge clk_in);
        addr_out <= a;
        rd_out <= 1'b1;
        @(posedge clk_in);
        rd_out <= 1'b0;
        addr_out <= ~a;
        @(negedge clk_in);
        rd_ok = rd_valid_in;
        rd_val = rd_data_in;
    endtask
endmodule // ipw_host_model

// File: tb/ipw_top_tb.sv
`timescale 1ns/100ps
// Self-checking bench for the interrupt pin configuration and key guard.
module ipw_top_tb;
    typedef struct packed {logic [2:0] cfg; logic irq; logic lvl; logic oe_n;} ipw_row_t;
    logic clk_in;
    logic reset_in;
    logic irq_in;
    logic [6:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
    logic [7:0] rd_data_out;
    logic rd_valid_out;
    logic ext_wr_out;
    logic [6:0] ext_addr_out;
    logic [7:0] ext_data_out;
    logic irq_pin_out;
    logic irq_pin_oe_n_out;
    int fail_count = 0;
    int n_checks = 0;
    logic [7:0] locked [4] = '{8'h00, 8'h84, 8'h87, 8'hFF};
    ipw_row_t rows [10] = '{'{3'h0, 1'b0, 1'b1, 1'b0}, '{3'h0, 1'b1, 1'b0, 1'b0}, '{3'h1, 1'b0, 1'b0, 1'b0},
        '{3'h1, 1'b1, 1'b1, 1'b0}, '{3'h2, 1'b0, 1'b1, 1'b1}, '{3'h2, 1'b1, 1'b0, 1'b0}, '{3'h3, 1'b0, 1'b0, 1'b1},
        '{3'h3, 1'b1, 1'b1, 1'b0}, '{3'h4, 1'b1, 1'b0, 1'b0}, '{3'h5, 1'b0, 1'b1, 1'b0}};

    ipw_top ipw_top_i (.clk_in(clk_in), .reset_in(reset_in), .addr_in(addr), .wr_in(wr), .rd_in(rd),
        .wr_data_in(wdata), .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out), .ext_wr_out(ext_wr_out),
        .ext_addr_out(ext_addr_out), .ext_data_out(ext_data_out), .irq_in(irq_in), .irq_pin_out(irq_pin_out),
        .irq_pin_oe_n_out(irq_pin_oe_n_out));
    ipw_host_model ipw_host_model_i (.clk_in(clk_in), .addr_out(addr), .wr_out(wr), .rd_out(rd),
        .data_out(wdata), .rd_data_in(rd_data_out), .rd_valid_in(rd_valid_out), .ext_wr_in(ext_wr_out));

    // Compares a value seen with the value expected and counts the result.
    task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
        n_checks++;
        if (s !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask

    // Reads a register and checks both the valid pulse and the data.
    task automatic rd_chk(input logic [6:0] a, input logic [7:0] e, input string n);
        ipw_host_model_i.rd_reg(a);
        check("rd_valid", {7'h00, ipw_host_model_i.rd_ok}, 8'h01);
        check(n, ipw_host_model_i.rd_val, e);
    endtask

    // Writes a register and checks whether it was forwarded.
    task automatic wr_chk(input logic [6:0] a, input logic [7:0] d, input logic fwd);
        ipw_host_model_i.wr_reg(a, d);
        check("ext_wr", {7'h00, ipw_host_model_i.ext_seen}, {7'h00, fwd});
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Free-running clock.
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    // Cuts a hang short.
    initial begin
        #50000;
        fail_count++;
        stop_test();
    end

    // Main sequence.
    initial begin
        reset_in = 1'b1;
        irq_in = 1'b0;
        repeat (4) @(posedge clk_in);
        reset_in <= 1'b0;
        @(negedge clk_in);
        check("pin_rst", {6'h00, irq_pin_out, irq_pin_oe_n_out}, 8'h03);
        rd_chk(7'h7D, 8'h02, "cfg_rst");
        rd_chk(7'h7E, 8'h85, "key_rst");
        rd_chk(7'h20, 8'h00, "unmapped");
        foreach (locked[k]) begin
            wr_chk(7'h7E, locked[k], 1'b0);
            wr_chk(7'h7D, 8'h07, 1'b0);
            wr_chk(7'h30, 8'h5A, 1'b0);
            rd_chk(7'h7D, 8'h02, "cfg_locked");
            rd_chk(7'h7E, locked[k], "key_locked");
        end
        wr_chk(7'h7E, 8'h85, 1'b0);
        wr_chk(7'h40, 8'h11, 1'b1);
        wr_chk(7'h41, 8'h22, 1'b1);
        check("ext_addr", {1'b0, ext_addr_out}, 8'h41);
        check("ext_data", ext_data_out, 8'h22);
        wr_chk(7'h7E, 8'h86, 1'b0);
        wr_chk(7'h7E, 8'h86, 1'b0);
        wr_chk(7'h50, 8'h33, 1'b1);
        rd_chk(7'h7E, 8'h00, "key_relock");
        wr_chk(7'h51, 8'h44, 1'b0);
        check("ext_addr_kept", {1'b0, ext_addr_out}, 8'h50);
        wr_chk(7'h7E, 8'h86, 1'b0);
        wr_chk(7'h7D, 8'h05, 1'b0);
        wr_chk(7'h7D, 8'h02, 1'b0);
        rd_chk(7'h7D, 8'h05, "cfg_single");
        wr_chk(7'h7E, 8'h85, 1'b0);
        foreach (rows[i]) begin
            wr_chk(7'h7D, {5'h1F, rows[i].cfg}, 1'b0);
            rd_chk(7'h7D, {5'h00, rows[i].cfg}, "cfg_rd");
            @(posedge clk_in);
            irq_in <= rows[i].irq;
            @(posedge clk_in);
            @(negedge clk_in);
            check("pin_lvl", {7'h00, irq_pin_out}, {7'h00, rows[i].lvl});
            check("pin_oe_n", {7'h00, irq_pin_oe_n_out}, {7'h00, rows[i].oe_n});
        end
        wr_chk(7'h7E, 8'h00, 1'b0);
        @(posedge clk_in);
        reset_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        reset_in <= 1'b0;
        rd_chk(7'h7E, 8'h85, "key_rst2");
        rd_chk(7'h7D, 8'h02, "cfg_rst2");
        stop_test();
    end
endmodule // ipw_top_tb
